// [rtl/ldd_dim_regs.sv]
// Behaviour
// R1: one dimming register per led; led2..led5 at 0x43..0x46 consecutively.
// R2: bits 11:0 hold the 12-bit duty code of that led's bypass switch.
// R3: duty decodes linearly: 0x000 off, each step 1/4095 period, 0xfff full.
// R4: bit 12 set disables dimming/fade; clear enables it (inverted polarity).
// R5: registers read back what was last written, zero after reset.
// R6: one dimming period lasts 8192 dimming clock cycles by default.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ldd_dim_regs #(
    parameter int PERIOD_CYCLES = ldd_pkg::PERIOD_CYCLES_DEF,
    parameter int DIM_CLK_DIV   = ldd_pkg::DIM_CLK_DIV_DEF
) (
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire ldd_pkg::ldd_req_t              bus_req,
    output logic [ldd_pkg::DATA_W-1:0]          reg_rdata,
    output logic [ldd_pkg::NUM_LED-1:0]         led_on,
    output logic [ldd_pkg::NUM_LED-1:0]         bypass_on,
    output logic                                period_start
);

    // ------------------------------------------------------------
    // constants sized for the counters
    // ------------------------------------------------------------
    localparam logic [ldd_pkg::CNT_W-1:0] PERIOD_LAST = ldd_pkg::CNT_W'(PERIOD_CYCLES - 1);
    localparam logic [ldd_pkg::CNT_W-1:0] DIV_LAST    = ldd_pkg::CNT_W'(DIM_CLK_DIV - 1);

    ldd_pkg::ldd_state_t s_q;
    ldd_pkg::ldd_state_t s_d;
    logic                dim_tick;
    logic                period_end;

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        dim_tick   = (s_q.div == DIV_LAST);
        period_end = dim_tick && (s_q.cnt == PERIOD_LAST);

        // dimming clock enable
        s_d.div = dim_tick ? '0 : s_q.div + 1'b1;

        // period counter
        if (dim_tick) begin
            s_d.cnt = period_end ? '0 : s_q.cnt + 1'b1; // see R6
        end

        // read data stand one cycle only
        s_d.rdata = '0;

        for (int i = 0; i < ldd_pkg::NUM_LED; i++) begin
            if (bus_req.wr && bus_req.addr == ldd_pkg::LED1_DIMMING_CTRL_OFS + 8'(i)) begin
                s_d.ctrl[i] = bus_req.wdata[ldd_pkg::REG_W-1:0]; // see R1
            end
            if (bus_req.rd && bus_req.addr == ldd_pkg::LED1_DIMMING_CTRL_OFS + 8'(i)) begin
                s_d.rdata = {3'h0, s_q.ctrl[i]}; // see R5
            end

            // fade enabled: new duty taken at period boundary only
            if (!s_q.ctrl[i][ldd_pkg::FADE_DIS_BIT]) begin
                if (period_end) begin
                    s_d.active[i] = s_q.ctrl[i][ldd_pkg::DUTY_MSB:ldd_pkg::DUTY_LSB]; // see R4
                end
            end else begin
                s_d.active[i] = s_q.ctrl[i][ldd_pkg::DUTY_MSB:ldd_pkg::DUTY_LSB]; // see R4
            end

            // on while cnt/period < duty/4095
            s_d.led_on[i] = (32'(s_q.cnt) * 32'(ldd_pkg::DUTY_STEPS))
                          < (32'(s_q.active[i]) * 32'(PERIOD_CYCLES)); // see R2, R3
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < ldd_pkg::NUM_LED; i++) begin
                s_q.ctrl[i]   <= ldd_pkg::DIM_CTRL_RESET; // see R5
                s_q.active[i] <= ldd_pkg::DUTY_OFF;
            end
            s_q.cnt    <= '0;
            s_q.div    <= '0;
            s_q.rdata  <= '0;
            s_q.led_on <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata    = s_q.rdata;
    assign led_on       = s_q.led_on;
    assign bypass_on    = ~s_q.led_on;
    assign period_start = (s_q.cnt == '0) && (s_q.div == '0);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic mapped_rd;
    assign mapped_rd = (bus_req.addr >= ldd_pkg::LED1_DIMMING_CTRL_OFS)
                    && (bus_req.addr <= ldd_pkg::LED5_DIMMING_CTRL_OFS);

    a_unmapped_read_zero: assert property ( // see R1
        (bus_req.rd && !mapped_rd) |=> (reg_rdata == '0))
        else $error("unmapped read returned nonzero data");

    a_rdata_one_cycle: assert property ( // see R5
        (!bus_req.rd) |=> (reg_rdata == '0))
        else $error("read data present without a read");

    a_period_wrap: assert property ( // see R6
        (dim_tick && s_q.cnt == PERIOD_LAST) |=> (s_q.cnt == '0) ##0 period_start)
        else $error("period counter did not wrap at period end");

    a_period_count: assert property ( // see R6
        (dim_tick && s_q.cnt != PERIOD_LAST) |=> (s_q.cnt == $past(s_q.cnt) + 1'b1))
        else $error("period counter skipped");

    a_cnt_wrap_only_end: assert property ( // see R6
        (s_q.cnt == '0 && $past(s_q.cnt) != '0)
        |-> $past(period_end))
        else $error("period counter wrapped before period end");

    // ------------------------------------------------------------
    // register bus checks
    // ------------------------------------------------------------
    a_rdata_top_zero: assert property ( // see R5
        reg_rdata[ldd_pkg::DATA_W-1:ldd_pkg::REG_W] == 3'h0)
        else $error("read data upper bits not zero");

    a_rdata_mapped_only: assert property ( // see R1
        (reg_rdata != '0)
        |-> $past(bus_req.rd && mapped_rd))
        else $error("read data without a mapped read");

    a_rd_keeps_regs: assert property ( // see R5
        bus_req.rd
        |=> $stable(s_q.ctrl))
        else $error("read altered a register");

    a_unmapped_wr_ignored: assert property ( // see R1
        (bus_req.wr && !mapped_rd)
        |=> $stable(s_q.ctrl))
        else $error("unmapped write altered a register");

    // ------------------------------------------------------------
    // dimming counter, output and per-led checks
    // ------------------------------------------------------------
    a_led_bypass_inv: assert property ( // see R2
        bypass_on == ~led_on)
        else $error("bypass command not inverse of led state");

    a_cnt_range: assert property ( // see R6
        s_q.cnt <= PERIOD_LAST)
        else $error("period counter out of range");

    a_div_range: assert property ( // see R6
        s_q.div <= DIV_LAST)
        else $error("divider out of range");

    a_cnt_hold_idle: assert property ( // see R6
        !dim_tick
        |=> $stable(s_q.cnt))
        else $error("period counter moved without a tick");

    a_div_step: assert property ( // see R6
        !dim_tick
        |=> (s_q.div == $past(s_q.div) + 1'b1))
        else $error("divider skipped");

    a_div_wrap: assert property ( // see R6
        dim_tick
        |=> (s_q.div == '0))
        else $error("divider did not wrap on tick");

    a_period_end_start: assert property ( // see R6
        period_end
        |=> period_start)
        else $error("no period start after period end");

    a_period_start_pulse: assert property ( // see R6
        period_start
        |=> !period_start)
        else $error("period start longer than one cycle");

    for (genvar g = 0; g < ldd_pkg::NUM_LED; g++) begin : g_chk
        localparam logic [7:0] OFS = ldd_pkg::LED1_DIMMING_CTRL_OFS + 8'(g);

        a_write_read_back: assert property ( // see R5
            (bus_req.wr && bus_req.addr == OFS ##1 bus_req.rd && bus_req.addr == OFS)
            |=> (reg_rdata == {3'h0, $past(bus_req.wdata[12:0], 2)}))
            else $error("read back differs from last write");

        a_fade_dis_direct: assert property ( // see R2, R4
            (bus_req.wr && bus_req.addr == OFS && bus_req.wdata[ldd_pkg::FADE_DIS_BIT]
             ##1 !(bus_req.wr && bus_req.addr == OFS))
            |=> (s_q.active[g] == $past(bus_req.wdata[11:0], 2)))
            else $error("duty not applied directly with dimming disabled");

        a_fade_en_hold: assert property ( // see R4
            (!s_q.ctrl[g][ldd_pkg::FADE_DIS_BIT] && !period_end)
            |=> $stable(s_q.active[g]))
            else $error("duty changed mid period with dimming enabled");

        a_duty_off: assert property ( // see R3
            (s_q.active[g] == ldd_pkg::DUTY_OFF) |=> !led_on[g])
            else $error("led on with zero duty");

        a_duty_full: assert property ( // see R3
            (s_q.active[g] == ldd_pkg::DUTY_FULL) |=> led_on[g] && !bypass_on[g])
            else $error("led off with full duty");
    end

    // ------------------------------------------------------------
    // per-led register and duty checks
    // ------------------------------------------------------------
    for (genvar g = 0; g < ldd_pkg::NUM_LED; g++) begin : g_led_chk
        localparam logic [7:0] OFS = ldd_pkg::LED1_DIMMING_CTRL_OFS + 8'(g);

        a_write_stores: assert property ( // see R1
            (bus_req.wr && bus_req.addr == OFS)
            |=> (s_q.ctrl[g] == $past(bus_req.wdata[ldd_pkg::REG_W-1:0])))
            else $error("write not stored in its register");

        a_write_other_keep: assert property ( // see R1
            (bus_req.wr && bus_req.addr != OFS)
            |=> $stable(s_q.ctrl[g]))
            else $error("write to another address altered register");

        a_ctrl_hold: assert property ( // see R5
            !(bus_req.wr && bus_req.addr == OFS)
            |=> $stable(s_q.ctrl[g]))
            else $error("register changed without a write");

        a_read_selects: assert property ( // see R5
            (bus_req.rd && bus_req.addr == OFS)
            |=> (reg_rdata[ldd_pkg::REG_W-1:0] == $past(s_q.ctrl[g])))
            else $error("read returned another register");

        a_fade_en_load: assert property ( // see R4
            (!s_q.ctrl[g][ldd_pkg::FADE_DIS_BIT] && period_end)
            |=> (s_q.active[g] == $past(s_q.ctrl[g][ldd_pkg::DUTY_MSB:ldd_pkg::DUTY_LSB])))
            else $error("duty not loaded at period end");

        a_fade_en_write_hold: assert property ( // see R4
            (bus_req.wr && bus_req.addr == OFS && !s_q.ctrl[g][ldd_pkg::FADE_DIS_BIT] && !period_end)
            |=> $stable(s_q.active[g]))
            else $error("write changed duty mid period with dimming enabled");

        a_fade_dis_follow: assert property ( // see R4
            s_q.ctrl[g][ldd_pkg::FADE_DIS_BIT]
            |=> (s_q.active[g] == $past(s_q.ctrl[g][ldd_pkg::DUTY_MSB:ldd_pkg::DUTY_LSB])))
            else $error("duty not followed with dimming disabled");

        a_active_source: assert property ( // see R4
            !$stable(s_q.active[g])
            |-> ($past(s_q.ctrl[g][ldd_pkg::FADE_DIS_BIT]) || $past(period_end)))
            else $error("duty changed from no allowed source");

        a_active_dis_steady: assert property ( // see R4
            (s_q.ctrl[g][ldd_pkg::FADE_DIS_BIT] && $stable(s_q.ctrl[g]))
            |=> $stable(s_q.active[g]))
            else $error("duty moved with register unchanged");

        a_led_on_start: assert property ( // see R3
            (period_start && s_q.active[g] != ldd_pkg::DUTY_OFF)
            |=> led_on[g])
            else $error("nonzero duty not lit at period start");

        a_led_monotone: assert property ( // see R3
            (!led_on[g] && s_q.cnt != '0 && $stable(s_q.active[g]))
            |=> !led_on[g])
            else $error("led relit within a period");

        a_bypass_zero_duty: assert property ( // see R2
            (s_q.active[g] == ldd_pkg::DUTY_OFF)
            |=> bypass_on[g])
            else $error("bypass open with zero duty");
    end

    c_write_then_read: cover property (
        bus_req.wr && bus_req.addr == ldd_pkg::LED3_DIMMING_CTRL_OFS
        ##1 bus_req.rd && bus_req.addr == ldd_pkg::LED3_DIMMING_CTRL_OFS);

    c_period_wrap: cover property (period_end ##1 period_start);

    c_led_toggle: cover property (led_on[0] ##1 !led_on[0]);

    c_fade_update: cover property (
        period_end && !s_q.ctrl[1][ldd_pkg::FADE_DIS_BIT]
        && s_q.active[1] != s_q.ctrl[1][11:0]);

    c_fade_dis_apply: cover property (
        bus_req.wr && bus_req.addr == ldd_pkg::LED5_DIMMING_CTRL_OFS
        && bus_req.wdata[ldd_pkg::FADE_DIS_BIT]);

endmodule

`default_nettype wire

// [rtl/ldd_pkg.sv]
`default_nettype none
package ldd_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NUM_LED   = 5;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 16;
    localparam int REG_W     = 13;
    localparam int DUTY_W    = 12;
    localparam int CNT_W     = 14;

    // ------------------------------------------------------------
    // register offsets, consecutive per led
    // ------------------------------------------------------------
    localparam logic [7:0] LED1_DIMMING_CTRL_OFS = 8'h42;
    localparam logic [7:0] LED2_DIMMING_CTRL_OFS = 8'h43;
    localparam logic [7:0] LED3_DIMMING_CTRL_OFS = 8'h44;
    localparam logic [7:0] LED4_DIMMING_CTRL_OFS = 8'h45;
    localparam logic [7:0] LED5_DIMMING_CTRL_OFS = 8'h46;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int          DUTY_LSB       = 0;
    localparam int          DUTY_MSB       = 11;
    localparam int          FADE_DIS_BIT   = 12;
    localparam logic [12:0] DIM_CTRL_RESET = 13'h0000;
    localparam logic [11:0] DUTY_OFF       = 12'h000;
    localparam logic [11:0] DUTY_FULL      = 12'hfff;
    localparam int          DUTY_STEPS     = 4095;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int PERIOD_CYCLES_DEF = 8192;
    localparam int DIM_CLK_DIV_DEF   = 1;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ldd_req_t;

    typedef struct packed {
        logic [NUM_LED-1:0][REG_W-1:0]  ctrl;
        logic [NUM_LED-1:0][DUTY_W-1:0] active;
        logic [CNT_W-1:0]               cnt;
        logic [CNT_W-1:0]               div;
        logic [DATA_W-1:0]              rdata;
        logic [NUM_LED-1:0]             led_on;
    } ldd_state_t;

endpackage
`default_nettype wire

// [test/ldd_gate_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------
// gate drivers: count lit cycles per period
// ---------------------------------------
module ldd_gate_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [4:0] bypass_on,
    input  wire logic       period_start,
    output var  int         lit_cnt [5],
    output var  int         per_len
);
    int acc [5];
    int len;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            len <= 0;
            per_len <= 0;
            foreach (acc[i]) begin
                acc[i] <= 0;
                lit_cnt[i] <= 0;
            end
        end else if (period_start === 1'b1) begin
            per_len <= len;
            len <= 1;
            foreach (acc[i]) begin
                lit_cnt[i] <= acc[i];
                acc[i] <= (bypass_on[i] === 1'b0) ? 1 : 0;
            end
        end else begin
            len <= len + 1;
            foreach (acc[i]) acc[i] <= acc[i] + ((bypass_on[i] === 1'b0) ? 1 : 0);
        end
    end
endmodule
`default_nettype wire

// [test/led_switch_duty_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module led_switch_duty_regs_tb;
    localparam int PER = 64;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    ldd_pkg::ldd_req_t req = '0;
    logic [15:0]       rdata;
    logic [4:0]        led_on;
    logic [4:0]        byp;
    logic              pstart;
    logic [15:0]       v;
    int                lit_cnt [5];
    int                per_len;
    int                err_total = 0;
    int                num_checks = 0;
    logic [11:0]       duty [5] = '{12'hfff, 12'h000, 12'h800, 12'h001, 12'h7ff};

    always #25 clk = ~clk;

    ldd_dim_regs #(.PERIOD_CYCLES(PER), .DIM_CLK_DIV(1)) dut (.clk(clk), .resetn(resetn),
        .bus_req(req), .reg_rdata(rdata), .led_on(led_on), .bypass_on(byp),
        .period_start(pstart));
    ldd_gate_model gates (.clk(clk), .resetn(resetn), .bypass_on(byp),
        .period_start(pstart), .lit_cnt(lit_cnt), .per_len(per_len));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask
    task wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        q = rdata;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, output logic [15:0] d);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task wait_ps;
        for (int k = 0; k < 4 * PER && pstart !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        @(posedge clk);
    endtask
    function automatic int exp_lit(input int d);
        int n = 0;
        for (int c = 0; c < PER; c++) if (c * 4095 < d * PER) n++;
        return n;
    endfunction
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ---------------------------------------
    // scenarios
    // ---------------------------------------
    task t_reset;
        for (int i = 0; i < 6; i++) begin
            rd(8'h42 + 8'(i), v);
            chk(v, 16'h0000);
        end
        chk(16'(byp), 16'h001f);
    endtask
    task t_regs;
        for (int i = 0; i < 6; i++) wr(8'h42 + 8'(i), 16'he1a5 + 16'(i * 16'h0321));
        for (int i = 0; i < 5; i++) begin
            rd(8'h42 + 8'(i), v);
            chk(v, (16'he1a5 + 16'(i * 16'h0321)) & 16'h1fff);
        end
        rd(8'h47, v);
        chk(v, 16'h0000);
    endtask
    task t_duty;
        for (int i = 0; i < 5; i++) wr(8'h42 + 8'(i), {4'h1, duty[i]});
        repeat (3) wait_ps;
        for (int i = 0; i < 5; i++) chk(16'(lit_cnt[i]), 16'(exp_lit(int'(duty[i]))));
        chk(16'(per_len), 16'(PER));
        rd(8'h44, v);
        chk(v, 16'h1800);
    endtask
    task t_fade;
        wait_ps;
        wr(8'h46, 16'h1000);
        repeat (3) @(negedge clk);
        chk(16'(led_on[4]), 16'h0000);
        @(posedge clk);
        wr(8'h46, 16'h0fff);
        repeat (3) @(negedge clk);
        chk(16'(led_on[4]), 16'h0000);
        @(posedge clk);
        repeat (3) wait_ps;
        chk(16'(lit_cnt[4]), 16'(PER));
    endtask
    task t_mid_reset;
        wr(8'h44, 16'h1abc);
        wr_rd(8'h45, 16'h0123, v);
        chk(v, 16'h0123);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(8'h44, v);
        chk(v, 16'h0000);
        chk(16'(byp), 16'h001f);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_regs;
        t_duty;
        t_fade;
        t_mid_reset;
        end_sim;
    end
    initial begin
        #(50 * 3000);
        err_total++;
        end_sim;
    end
endmodule
`default_nettype wire
